// ### src/lpsc_pkg.sv
// Shared constants and types for the lighting plot store control
package lpsc_pkg;
  localparam int NUM_CH   = 128;
  localparam int CH_W     = 7;
  localparam int NUM_FILE = 100;
  localparam int FILE_W   = 7;
  localparam int LVL_W    = 7;
  localparam int AUX_N    = 50;
  localparam int TMR_W    = 24;
  localparam logic [CH_W-1:0]   CH_LAST   = 7'h7f;
  localparam logic [FILE_W-1:0] FILE_LAST = 7'h63;
  // Full level; a full-to-off fade is this many increments
  localparam logic [LVL_W-1:0]  LVL_FULL  = 7'h50;
  // Filed levels land on one of 20 steps of this size
  localparam logic [LVL_W-1:0]  FILE_STEP = 7'h04;
  localparam logic [LVL_W-1:0]  MIM_FIXED = 7'h28;

  typedef struct packed {
    logic             on;
    logic [LVL_W-1:0] lvl;
  } lpsc_entry_t;

  localparam lpsc_entry_t ENTRY_RST = 8'h00;

  typedef struct packed {
    logic             en;
    logic [CH_W-1:0]  ch;
    logic [LVL_W-1:0] lvl;
  } lpsc_aux_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_FILE, OP_CUT, OP_ADD, OP_SUB, OP_ROFF, OP_RSET, OP_RBOTH
  } lpsc_op_t;

  typedef enum logic [1:0] {SW_IDLE, SW_OP, SW_XSTART, SW_XSTEP} lpsc_sw_t;

  typedef struct packed {
    logic [11:0]      ch_bcd;
    logic             ch_store;
    logic             ch_toggle;
    logic             ch_set;
    logic [LVL_W-1:0] ch_lvl;
    logic [7:0]       file_bcd;
    logic             op_req;
    logic [2:0]       op_code;
    logic             op_store;
    logic [LVL_W-1:0] rst_lvl;
    logic             xf_go;
    logic             mix;
    logic             remainder_zeroing;
    logic             auto_xf;
    logic             advance;
    logic [LVL_W-1:0] master_out;
    logic [LVL_W-1:0] master_pre;
    logic [TMR_W-1:0] up_delay;
    logic [TMR_W-1:0] up_rate;
    logic [TMR_W-1:0] dn_delay;
    logic [TMR_W-1:0] dn_rate;
  } lpsc_panel_t;
endpackage

// ### src/lpsc_top.sv
// Plot store control: stores, file area, cross-fade and dimmer scan
module lpsc_sync #(parameter int W = 1) (
  input  wire logic         i_clk,  // System clock
  input  wire logic         i_srst, // Synchronous reset
  input  wire logic [W-1:0] i_d,    // Asynchronous input
  output logic      [W-1:0] o_q     // Synchronised output
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule

module lpsc_fade_tmr (
  input  wire logic                         i_clk,   // System clock
  input  wire logic                         i_srst,  // Synchronous reset
  input  wire logic                         i_start, // Start pulse
  input  wire logic [lpsc_pkg::TMR_W-1:0]   i_delay, // Cycles before first
  input  wire logic [lpsc_pkg::TMR_W-1:0]   i_rate,  // Cycles per step - 1
  output logic      [lpsc_pkg::LVL_W-1:0]   o_k,     // Increments done
  output logic                              o_inc    // Increment pulse
);
  logic [lpsc_pkg::TMR_W-1:0] cnt;
  logic                       run;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cnt   <= '0;
      run   <= 1'b0;
      o_k   <= lpsc_pkg::LVL_FULL;
      o_inc <= 1'b0;
    end
    else if (i_start)
    begin
      cnt   <= i_delay;
      run   <= 1'b1;
      o_k   <= '0;
      o_inc <= 1'b0;
    end
    else if (run && cnt == '0)
    begin
      cnt   <= i_rate;
      o_k   <= o_k + 7'h01;
      o_inc <= 1'b1;
      run   <= (o_k + 7'h01) != lpsc_pkg::LVL_FULL;
    end
    else
    begin
      cnt   <= run ? cnt - 24'h000001 : cnt;
      o_inc <= 1'b0;
    end
  end
endmodule

module lpsc_top (
  input  wire logic                        I_CLK,        // 250 MHz clock
  input  wire logic                        I_SRST,       // Sync reset, high
  input  wire logic [11:0]                 I_CH_BCD,     // Channel, 3 BCD
  input  wire logic                        I_CH_STORE,   // 0 output, 1 preset
  input  wire logic                        I_CH_TOGGLE,  // On/off button
  input  wire logic                        I_CH_SET,     // Set level button
  input  wire logic [lpsc_pkg::LVL_W-1:0]  I_CH_LVL,     // Set level value
  input  wire logic [7:0]                  I_FILE_BCD,   // File, 2 BCD
  input  wire logic                        I_OP_REQ,     // File/reset button
  input  wire logic [2:0]                  I_OP_CODE,    // lpsc_op_t code
  input  wire logic                        I_OP_STORE,   // 0 output, 1 preset
  input  wire logic [lpsc_pkg::LVL_W-1:0]  I_RST_LVL,    // Store reset level
  input  wire logic                        I_XF_GO,      // Cross-fade start
  input  wire logic                        I_MIX,        // Mix stores
  input  wire logic                        I_REMAINDER_ZEROING,   // remainder_zeroing
  input  wire logic                        I_AUTO_XF,    // Auto true fade
  input  wire logic                        I_ADVANCE,    // file_auto_advance
  input  wire logic [lpsc_pkg::LVL_W-1:0]  I_MASTER_OUT, // Output master
  input  wire logic [lpsc_pkg::LVL_W-1:0]  I_MASTER_PRE, // Preset master
  input  wire logic [lpsc_pkg::TMR_W-1:0]  I_UP_DELAY,   // Fade-up start
  input  wire logic [lpsc_pkg::TMR_W-1:0]  I_UP_RATE,    // Fade-up step
  input  wire logic [lpsc_pkg::TMR_W-1:0]  I_DN_DELAY,   // Fade-down start
  input  wire logic [lpsc_pkg::TMR_W-1:0]  I_DN_RATE,    // Fade-down step
  input  wire lpsc_pkg::lpsc_aux_t [lpsc_pkg::AUX_N-1:0] I_AUX, // Aux patch
  output logic      [lpsc_pkg::CH_W-1:0]   O_DIM_CH,     // Scanned channel
  output logic      [lpsc_pkg::LVL_W-1:0]  O_DIM_LVL,    // Dimmer level
  output logic      [lpsc_pkg::LVL_W-1:0]  O_MIM_OUT,    // Output mimic
  output logic      [lpsc_pkg::LVL_W-1:0]  O_MIM_PRE,    // Preset mimic
  output logic      [lpsc_pkg::NUM_FILE-1:0] O_FMIM_OUT, // Output files
  output logic      [lpsc_pkg::NUM_FILE-1:0] O_FMIM_PRE, // Preset files
  output logic      [lpsc_pkg::FILE_W-1:0] O_FILE_SEL,   // Selected file
  output logic                             O_SEL_ON,     // Sel channel on
  output logic      [lpsc_pkg::LVL_W-1:0]  O_SEL_LVL,    // Sel channel meter
  output logic                             O_BUSY,       // Operation pending
  output logic                             O_FADING      // Cross-fade running
);
  localparam int NCH = lpsc_pkg::NUM_CH;
  localparam int NF  = lpsc_pkg::NUM_FILE;
  localparam int LW  = lpsc_pkg::LVL_W;

  lpsc_pkg::lpsc_panel_t pin, ps, ps_d;
  lpsc_pkg::lpsc_entry_t out_st [NCH];
  lpsc_pkg::lpsc_entry_t pre_st [NCH];
  lpsc_pkg::lpsc_entry_t file_st [NF][NCH];
  logic [LW-1:0] fx_from [NCH];
  logic [LW-1:0] fx_to [NCH];
  logic          fx_mv [NCH];

  lpsc_pkg::lpsc_sw_t    sw;
  lpsc_pkg::lpsc_op_t    op, op_pend;
  lpsc_pkg::lpsc_entry_t cur_out, cur_pre, cur_file, nx_e, ed_e, ed_cur;
  logic [lpsc_pkg::CH_W-1:0]   scan;
  logic [lpsc_pkg::FILE_W-1:0] fsel, op_file, next_fsel;
  logic [9:0]    ch_num;
  logic          ch_ok, op_store, pend_store, xs_pend, step_pend;
  logic          ed_tog, ed_set, ed_fire, true_xf, last, sw_end;
  logic          wr_out, wr_pre, wr_file, fade_last, up_inc, dn_inc, xs_done;
  logic [LW-1:0] k_up, k_dn, k, so, sp, aux_max, next_dim;
  logic signed [8:0]  d9;
  logic signed [16:0] q17;

  always_comb
  begin
    pin = {I_CH_BCD, I_CH_STORE, I_CH_TOGGLE, I_CH_SET, I_CH_LVL, I_FILE_BCD,
           I_OP_REQ, I_OP_CODE, I_OP_STORE, I_RST_LVL, I_XF_GO, I_MIX,
           I_REMAINDER_ZEROING, I_AUTO_XF, I_ADVANCE, I_MASTER_OUT, I_MASTER_PRE,
           I_UP_DELAY, I_UP_RATE, I_DN_DELAY, I_DN_RATE};
  end

  lpsc_sync #(.W($bits(lpsc_pkg::lpsc_panel_t))) u_sync (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .i_d    (pin),
    .o_q    (ps)
  );

  // Aux patch arrives from the panel side, so it is synchronised too
  lpsc_pkg::lpsc_aux_t [lpsc_pkg::AUX_N-1:0] aux;
  lpsc_sync #(.W($bits(aux))) u_aux_sync (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .i_d    (I_AUX),
    .o_q    (aux)
  );

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      ps_d <= '0;
    else
      ps_d <= ps;
  end

  function automatic logic [LW-1:0] scale(lpsc_pkg::lpsc_entry_t e,
                                          logic [LW-1:0] m);
    logic [13:0] p;
    p = e.lvl * m;
    scale = e.on ? LW'(p / 14'(lpsc_pkg::LVL_FULL)) : '0;
  endfunction

  always_comb
  begin
    ch_num = 10'(ps.ch_bcd[11:8]) * 10'd100 + 10'(ps.ch_bcd[7:4]) * 10'd10
           + 10'(ps.ch_bcd[3:0]);
    ch_ok  = ch_num < 10'(NCH);
    ed_cur = ps.ch_store ? pre_st[ch_num[6:0]] : out_st[ch_num[6:0]];
    ed_e   = ed_cur;
    if (ed_tog)
      ed_e.on = ~ed_cur.on;
    if (ed_set)
      ed_e.lvl = ps.ch_lvl;
    ed_fire = (ed_tog || ed_set) && sw == lpsc_pkg::SW_IDLE;
  end

  always_comb
  begin
    cur_out   = out_st[scan];
    cur_pre   = pre_st[scan];
    cur_file  = file_st[op_file][scan];
    last      = scan == lpsc_pkg::CH_LAST;
    sw_end    = last && sw != lpsc_pkg::SW_IDLE;
    fade_last = k_up == lpsc_pkg::LVL_FULL && k_dn == lpsc_pkg::LVL_FULL;
    k         = fx_to[scan] > fx_from[scan] ? k_up : k_dn;
    d9        = $signed({2'b00, fx_to[scan]}) - $signed({2'b00, fx_from[scan]});
    // level = from + diff*k/80, one code per increment at most
    q17       = (d9 * $signed({1'b0, k})) / $signed({10'h000, lpsc_pkg::LVL_FULL});
    nx_e      = op_store ? cur_pre : cur_out;
    wr_out    = 1'b0;
    wr_pre    = 1'b0;
    wr_file   = 1'b0;
    case (sw)
      lpsc_pkg::SW_OP:
      begin
        case (op)
          // unscaled level, rounded to a step
          lpsc_pkg::OP_FILE:
          begin
            nx_e.lvl = ((nx_e.lvl + (lpsc_pkg::FILE_STEP >> 1))
                        / lpsc_pkg::FILE_STEP) * lpsc_pkg::FILE_STEP;
          end
          lpsc_pkg::OP_CUT: nx_e = cur_file;
          lpsc_pkg::OP_ADD: nx_e = cur_file.on ? cur_file : nx_e;
          lpsc_pkg::OP_SUB: nx_e.on = nx_e.on & ~cur_file.on;
          lpsc_pkg::OP_ROFF: nx_e.on = 1'b0;
          lpsc_pkg::OP_RSET: nx_e.lvl = ps.rst_lvl;
          lpsc_pkg::OP_RBOTH: nx_e = {1'b0, ps.rst_lvl};
          default: nx_e = nx_e;
        endcase
        // file written from the chosen store only
        wr_file = op == lpsc_pkg::OP_FILE;
        wr_out  = !wr_file && !op_store;
        wr_pre  = !wr_file && op_store;
      end
      lpsc_pkg::SW_XSTART:
      begin
        nx_e.on  = cur_out.on | cur_pre.on;
        nx_e.lvl = cur_pre.on && !cur_out.on ? '0 : cur_out.lvl;
        wr_out   = 1'b1;
      end
      lpsc_pkg::SW_XSTEP:
      begin
        nx_e     = cur_out;
        // each channel takes the whole set time
        nx_e.lvl = LW'(q17 + $signed({10'h000, fx_from[scan]}));
        if (fade_last && fx_to[scan] == '0 && !cur_pre.on)
          nx_e.on = 1'b0;
        wr_out = fx_mv[scan];
      end
      default: nx_e = nx_e;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
      scan <= '0;
    else
      scan <= scan + 7'h01;
  end

  // Sweep sequencing: one whole-store pass per operation
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      sw       <= lpsc_pkg::SW_IDLE;
      op       <= lpsc_pkg::OP_NONE;
      op_store <= 1'b0;
    end
    else if (last)
    begin
      sw <= lpsc_pkg::SW_IDLE;
      if (op_pend != lpsc_pkg::OP_NONE)
      begin
        sw       <= lpsc_pkg::SW_OP;
        op       <= op_pend;
        op_store <= pend_store;
      end
      else if (xs_pend)
        sw <= lpsc_pkg::SW_XSTART;
      else if (step_pend)
        sw <= lpsc_pkg::SW_XSTEP;
    end
  end

  // Requests; a new operation request in a clearing cycle is lost, a new cross-fade or step request is kept
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      op_pend    <= lpsc_pkg::OP_NONE;
      pend_store <= 1'b0;
      xs_pend    <= 1'b0;
      step_pend  <= 1'b0;
      ed_tog     <= 1'b0;
      ed_set     <= 1'b0;
      true_xf    <= 1'b0;
    end
    else
    begin
      if (last && op_pend != lpsc_pkg::OP_NONE)
        op_pend <= lpsc_pkg::OP_NONE;
      else if (ps.op_req && !ps_d.op_req && op_pend == lpsc_pkg::OP_NONE)
      begin
        op_pend    <= lpsc_pkg::lpsc_op_t'(ps.op_code);
        pend_store <= ps.op_store;
      end
      if (ps.xf_go && !ps_d.xf_go && !O_FADING)
      begin
        xs_pend <= 1'b1;
        // true cross-fade fades out the rest
        true_xf <= ps.remainder_zeroing || ps.auto_xf;
      end
      else if (last && op_pend == lpsc_pkg::OP_NONE)
        xs_pend <= 1'b0;
      if (up_inc || dn_inc)
        step_pend <= 1'b1;
      else if (last && op_pend == lpsc_pkg::OP_NONE && !xs_pend)
        step_pend <= 1'b0;
      ed_tog <= (ps.ch_toggle && !ps_d.ch_toggle && ch_ok) || (ed_tog && !ed_fire);
      ed_set <= (ps.ch_set && !ps_d.ch_set && ch_ok) || (ed_set && !ed_fire);
    end
  end

  // preset edits touch only the preset array
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      for (int i = 0; i < NCH; i++)
        pre_st[i] <= lpsc_pkg::ENTRY_RST;
    end
    else if (wr_pre)
      pre_st[scan] <= nx_e;
    else if (ed_fire && ps.ch_store)
      pre_st[ch_num[6:0]] <= ed_e;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      for (int i = 0; i < NCH; i++)
        out_st[i] <= lpsc_pkg::ENTRY_RST;
    end
    else if (wr_out)
      out_st[scan] <= nx_e;
    else if (ed_fire && !ps.ch_store)
      out_st[ch_num[6:0]] <= ed_e;
  end

  // File contents are memory and survive reset
  always_ff @(posedge I_CLK)
  begin
    if (wr_file)
      file_st[op_file][scan] <= nx_e;
  end

  // only preset-on channels move unless true cross-fade (zeroing or auto)
  always_ff @(posedge I_CLK)
  begin
    if (sw == lpsc_pkg::SW_XSTART)
    begin
      fx_from[scan] <= cur_out.on ? cur_out.lvl : '0;
      fx_to[scan]   <= cur_pre.on ? cur_pre.lvl : '0;
      fx_mv[scan]   <= cur_pre.on || (true_xf && cur_out.on);
    end
  end

  assign xs_done = sw_end && sw == lpsc_pkg::SW_XSTART;

  lpsc_fade_tmr u_up (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_start (xs_done),
    .i_delay (ps.up_delay),
    .i_rate  (ps.up_rate),
    .o_k     (k_up),
    .o_inc   (up_inc)
  );

  lpsc_fade_tmr u_dn (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_start (xs_done),
    .i_delay (ps.dn_delay),
    .i_rate  (ps.dn_rate),
    .o_k     (k_dn),
    .o_inc   (dn_inc)
  );

  // only an executed operation consumes the file number
  always_comb
  begin
    next_fsel = fsel;
    if (ps.file_bcd != ps_d.file_bcd)
      next_fsel = FILE_W_CAST(ps.file_bcd);
    else if (sw_end && sw == lpsc_pkg::SW_OP && ps.advance)
      next_fsel = op_file == lpsc_pkg::FILE_LAST ? '0 : op_file + 7'h01;
  end

  function automatic logic [6:0] FILE_W_CAST(logic [7:0] b);
    FILE_W_CAST = 7'(b[7:4]) * 7'd10 + 7'(b[3:0]);
  endfunction

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      fsel    <= '0;
      op_file <= '0;
    end
    else
    begin
      fsel <= next_fsel;
      if (last && op_pend != lpsc_pkg::OP_NONE)
        op_file <= fsel;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_FMIM_OUT <= '0;
      O_FMIM_PRE <= '0;
      O_FADING   <= 1'b0;
    end
    else
    begin
      if (sw_end && sw == lpsc_pkg::SW_OP && op < lpsc_pkg::OP_ROFF)
      begin
        if (op_store)
          O_FMIM_PRE <= (op == lpsc_pkg::OP_CUT ? '0 : O_FMIM_PRE)
                      | (NF'(1) << op_file);
        else
          O_FMIM_OUT <= (op == lpsc_pkg::OP_CUT ? '0 : O_FMIM_OUT)
                      | (NF'(1) << op_file);
      end
      else if (ps.xf_go && !ps_d.xf_go && !O_FADING)
      begin
        O_FMIM_OUT <= O_FMIM_OUT | O_FMIM_PRE;
        O_FADING   <= 1'b1;
      end
      // Only the sweep after the last increment may end the fade
      else if (sw_end && sw == lpsc_pkg::SW_XSTEP && fade_last
               && !step_pend && !up_inc && !dn_inc)
      begin
        O_FADING <= 1'b0;
        if (true_xf)
          O_FMIM_OUT <= O_FMIM_PRE;
      end
    end
  end

  // masters act on the drive path only
  always_comb
  begin
    so       = scale(cur_out, ps.master_out);
    sp       = ps.mix ? scale(cur_pre, ps.master_pre) : '0;
    aux_max  = '0;
    for (int i = 0; i < lpsc_pkg::AUX_N; i++)
      if (aux[i].en && aux[i].ch == scan && aux[i].lvl > aux_max)
        aux_max = aux[i].lvl;
    next_dim = sp > so ? sp : so;
    next_dim = aux_max > next_dim ? aux_max : next_dim;
  end

  // output mimic from drive, preset mimic fixed
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_DIM_CH  <= '0;
      O_DIM_LVL <= '0;
      O_MIM_OUT <= '0;
      O_MIM_PRE <= '0;
      O_SEL_ON  <= 1'b0;
      O_SEL_LVL <= '0;
    end
    else
    begin
      O_DIM_CH  <= scan;
      O_DIM_LVL <= next_dim;
      O_MIM_OUT <= next_dim;
      O_MIM_PRE <= cur_pre.on ? lpsc_pkg::MIM_FIXED : '0;
      O_SEL_ON  <= ed_cur.on;
      O_SEL_LVL <= ed_cur.lvl;
    end
  end

  assign O_FILE_SEL = fsel;
  assign O_BUSY     = op_pend != lpsc_pkg::OP_NONE || sw != lpsc_pkg::SW_IDLE;

  sequence s_op_end;
    sw == lpsc_pkg::SW_OP && last && ps.advance
      && ps.file_bcd == ps_d.file_bcd;
  endsequence

  a_file_quant: assert property (@(posedge I_CLK) disable iff (I_SRST)
    wr_file |-> nx_e.lvl % lpsc_pkg::FILE_STEP == '0)
    else $error("filed level off step");
  a_dim_off: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (!ps.mix && !cur_out.on && aux_max == '0) |=> O_DIM_LVL == '0)
    else $error("off channel drives dimmer");
  a_mix_high: assert property (@(posedge I_CLK) disable iff (I_SRST)
    ps.mix |=> O_DIM_LVL >= $past(sp) && O_DIM_LVL >= $past(so))
    else $error("mix not highest");
  a_file_adv: assert property (@(posedge I_CLK) disable iff (I_SRST)
    s_op_end |=> fsel == ($past(op_file) == lpsc_pkg::FILE_LAST ? 7'h00
                          : $past(op_file) + 7'h01))
    else $error("file not advanced");
  a_sub_off: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (sw == lpsc_pkg::SW_OP && op == lpsc_pkg::OP_SUB && !op_store
     && cur_file.on) |=> !out_st[$past(scan)].on)
    else $error("subtract left channel on");
  a_step_even: assert property (@(posedge I_CLK) disable iff (I_SRST)
    k_up != $past(k_up) |-> k_up == $past(k_up) + 7'h01 || k_up == '0)
    else $error("fade increment uneven");
  a_equal_hold: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (sw == lpsc_pkg::SW_XSTEP && fx_from[scan] == fx_to[scan] && fx_mv[scan])
    |=> out_st[$past(scan)].lvl == $past(fx_from[scan]))
    else $error("equal level moved");
  a_xf_mimic: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (ps.xf_go && !ps_d.xf_go && !O_FADING && !(sw_end && sw == lpsc_pkg::SW_OP))
    |=> (O_FMIM_OUT & $past(O_FMIM_PRE)) == $past(O_FMIM_PRE))
    else $error("preset files not added");
  a_preset_kept: assert property (@(posedge I_CLK) disable iff (I_SRST)
    sw == lpsc_pkg::SW_XSTEP |=> pre_st[$past(scan)] == $past(cur_pre))
    else $error("fade changed preset");
endmodule

// ### tb/lpsc_dimmer_model.sv
// Dimmer drive model: latches each scanned channel level
module lpsc_dimmer_model (
  input  wire logic                       i_clk, // System clock
  input  wire logic [lpsc_pkg::CH_W-1:0]  i_ch,  // Scanned channel
  input  wire logic [lpsc_pkg::LVL_W-1:0] i_lvl, // Drive level
  output logic      [lpsc_pkg::CH_W-1:0]  o_ch,  // Latched channel
  output logic      [lpsc_pkg::LVL_W-1:0] o_lvl  // Latched level
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_clk)
  begin
    o_ch  <= i_ch;
    o_lvl <= i_lvl;
  end
endmodule

// ### tb/lpsc_top_bench.sv
// Self-checking bench for the plot store control
module lpsc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {bit k; logic [6:0] c; logic [6:0] e;} lpsc_note_t;
  logic                  clk  = 1'b0;
  logic                  srst = 1'b1;
  lpsc_pkg::lpsc_panel_t pnl  = '0;
  lpsc_pkg::lpsc_aux_t [lpsc_pkg::AUX_N-1:0] aux = '0;
  logic [6:0]            dim_ch, dim_lvl, mim_pre, file_sel, m_ch, m_lvl;
  logic [6:0]            lv, fl, mim_out, mim_d, sel_lvl;
  logic                  sel_on;
  logic [lpsc_pkg::NUM_FILE-1:0] fmo, fmp;
  logic                  busy, fading;
  int                    err_total = 0;
  int                    samples_checked = 0;
  int                    seed = 32'h5eba988f;
  lpsc_note_t            notes[$];

  always #2 clk = ~clk;

  lpsc_top i_lpsc_top (.I_CLK(clk), .I_SRST(srst), .I_CH_BCD(pnl.ch_bcd),
    .I_CH_STORE(pnl.ch_store), .I_CH_TOGGLE(pnl.ch_toggle),
    .I_CH_SET(pnl.ch_set), .I_CH_LVL(pnl.ch_lvl), .I_FILE_BCD(pnl.file_bcd),
    .I_OP_REQ(pnl.op_req), .I_OP_CODE(pnl.op_code), .I_OP_STORE(pnl.op_store),
    .I_RST_LVL(pnl.rst_lvl), .I_XF_GO(pnl.xf_go), .I_MIX(pnl.mix),
    .I_REMAINDER_ZEROING(pnl.remainder_zeroing), .I_AUTO_XF(pnl.auto_xf),
    .I_ADVANCE(pnl.advance), .I_MASTER_OUT(pnl.master_out),
    .I_MASTER_PRE(pnl.master_pre), .I_UP_DELAY(pnl.up_delay),
    .I_UP_RATE(pnl.up_rate), .I_DN_DELAY(pnl.dn_delay),
    .I_DN_RATE(pnl.dn_rate), .I_AUX(aux), .O_DIM_CH(dim_ch),
    .O_DIM_LVL(dim_lvl), .O_MIM_OUT(mim_out), .O_MIM_PRE(mim_pre),
    .O_FMIM_OUT(fmo), .O_FMIM_PRE(fmp), .O_FILE_SEL(file_sel),
    .O_SEL_ON(sel_on), .O_SEL_LVL(sel_lvl),
    .O_BUSY(busy), .O_FADING(fading));

  lpsc_dimmer_model i_lpsc_dimmer_model (.i_clk(clk), .i_ch(dim_ch),
    .i_lvl(dim_lvl), .o_ch(m_ch), .o_lvl(m_lvl));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check_val(input string nm, input logic [6:0] e,
                           input logic [6:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask

  task automatic note(input bit k, input logic [6:0] c, input logic [6:0] e);
    notes.push_back('{k, c, e});
  endtask

  // Bounded wait for the monitor to consume all notes
  task automatic drain();
    int n;
    n = 0;
    while (notes.size() != 0 && n < 600)
    begin
      cyc(1);
      n++;
    end
    if (notes.size() != 0)
      check_val("queue", 7'h00, 7'(notes.size()));
    notes.delete();
  endtask

  // Channel set up four cycles before the button so it has crossed the sync first
  task automatic edit(input bit st, input logic [11:0] bcd, input bit set,
                      input logic [6:0] lvl);
    pnl.ch_store <= st;
    pnl.ch_bcd <= bcd;
    pnl.ch_lvl <= lvl;
    cyc(4);
    if (set)
      pnl.ch_set <= 1'b1;
    else
      pnl.ch_toggle <= 1'b1;
    cyc(5);
    pnl.ch_set <= 1'b0;
    pnl.ch_toggle <= 1'b0;
    cyc(5);
  endtask

  task automatic op(input lpsc_pkg::lpsc_op_t c, input bit st,
                    input logic [7:0] f);
    int n;
    pnl.op_code <= c;
    pnl.op_store <= st;
    pnl.file_bcd <= f;
    cyc(4);
    pnl.op_req <= 1'b1;
    cyc(5);
    pnl.op_req <= 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 600)
    begin
      cyc(1);
      n++;
    end
    check_val("busy", 7'h00, {6'h00, busy});
    cyc(2);
  endtask

  task automatic xfade();
    int n;
    pnl.xf_go <= 1'b1;
    cyc(5);
    pnl.xf_go <= 1'b0;
    n = 0;
    while (fading !== 1'b0 && n < 25000)
    begin
      cyc(1);
      n++;
    end
    check_val("fading", 7'h00, {6'h00, fading});
  endtask

  // Output mimic delayed to line up with the dimmer model
  always @(posedge clk)
    mim_d <= mim_out;

  // Oldest note is judged when its channel comes round in the scan
  always @(posedge clk)
    if (notes.size() != 0)
      if (notes[0].k ? (dim_ch === notes[0].c) : (m_ch === notes[0].c))
      begin
        check_val(notes[0].k ? "mimic" : "dimmer", notes[0].e,
                  notes[0].k ? mim_pre : m_lvl);
        if (!notes[0].k)
          check_val("out mimic", notes[0].e, mim_d);
        void'(notes.pop_front());
      end

  task automatic final_report();
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_total++;
    final_report();
  end

  initial
  begin
    cyc(3);
    srst <= 1'b0;
    pnl.master_out <= lpsc_pkg::LVL_FULL;
    pnl.master_pre <= lpsc_pkg::LVL_FULL;
    pnl.up_rate <= 24'h80;
    pnl.dn_rate <= 24'h80;
    aux[0] <= '{1'b1, 7'h09, 7'h21};
    lv = 7'(8 + $unsigned($random(seed)) % 73);
    fl = 7'(((lv + 2) / 4) * 4);
    edit(0, 12'h005, 0, 7'h00);
    edit(0, 12'h005, 1, lv);
    check_val("sel level", lv, sel_lvl);
    check_val("sel on", 7'h01, {6'h00, sel_on});
    note(0, 7'h05, lv);
    note(0, 7'h09, 7'h21);
    note(0, 7'h06, 7'h00);
    drain();
    edit(0, 12'h005, 0, 7'h00);
    note(0, 7'h05, 7'h00);
    drain();
    edit(0, 12'h005, 0, 7'h00);
    note(0, 7'h05, lv);
    drain();
    edit(1, 12'h007, 0, 7'h00);
    edit(1, 12'h007, 1, 7'h3c);
    note(0, 7'h07, 7'h00);
    note(1, 7'h07, lpsc_pkg::MIM_FIXED);
    note(1, 7'h05, 7'h00);
    drain();
    pnl.mix <= 1'b1;
    pnl.master_pre <= 7'h28;
    cyc(8);
    note(0, 7'h07, 7'h1e);
    drain();
    // Filing at half master, mixing still on
    pnl.master_out <= 7'h28;
    op(lpsc_pkg::OP_FILE, 0, 8'h03);
    op(lpsc_pkg::OP_FILE, 1, 8'h04);
    pnl.mix <= 1'b0;
    pnl.master_out <= lpsc_pkg::LVL_FULL;
    pnl.master_pre <= lpsc_pkg::LVL_FULL;
    op(lpsc_pkg::OP_ROFF, 0, 8'h03);
    note(0, 7'h05, 7'h00);
    drain();
    op(lpsc_pkg::OP_CUT, 0, 8'h03);
    note(0, 7'h05, fl);
    drain();
    pnl.rst_lvl <= 7'h14;
    op(lpsc_pkg::OP_RSET, 0, 8'h03);
    note(0, 7'h05, 7'h14);
    drain();
    op(lpsc_pkg::OP_CUT, 0, 8'h04);
    note(0, 7'h05, 7'h00);
    note(0, 7'h07, 7'h3c);
    drain();
    op(lpsc_pkg::OP_ADD, 0, 8'h03);
    note(0, 7'h05, fl);
    note(0, 7'h07, 7'h3c);
    drain();
    check_val("file mimic out", 7'h18, 7'(fmo));
    pnl.advance <= 1'b1;
    op(lpsc_pkg::OP_SUB, 0, 8'h04);
    pnl.advance <= 1'b0;
    check_val("file", 7'h05, file_sel);
    note(0, 7'h07, 7'h00);
    note(0, 7'h05, fl);
    drain();
    xfade();
    note(0, 7'h07, 7'h3c);
    note(0, 7'h05, fl);
    note(1, 7'h07, lpsc_pkg::MIM_FIXED);
    drain();
    pnl.remainder_zeroing <= 1'b1;
    xfade();
    note(0, 7'h05, 7'h00);
    note(0, 7'h07, 7'h3c);
    drain();
    check_val("file mimic out", 7'h10, 7'(fmo));
    check_val("file mimic pre", 7'h10, 7'(fmp));
    final_report();
  end
endmodule
